/* rfifo_map.svh */
// Constants for the ripple FIFO host controller
// ****************************************************
// ****************************************************
`ifndef RFIFO_MAP_SVH
`define RFIFO_MAP_SVH
`define RFIFO_WIDTH      9
`define RFIFO_DEPTH      64
`define RFIFO_CNT_W      7
// Clear low time 100 ns, rounded up at 5 ns per cycle
`define RFIFO_CLR_NS     100
`define RFIFO_CLK_NS     5
`define RFIFO_CLR_CYC    ((`RFIFO_CLR_NS + `RFIFO_CLK_NS - 1) / `RFIFO_CLK_NS)
// Strobe half period 15 ns: with the idle cycle, a word every 35 ns, near 28.6 MHz
`define RFIFO_STB_NS     15
`define RFIFO_STB_CYC    ((`RFIFO_STB_NS + `RFIFO_CLK_NS - 1) / `RFIFO_CLK_NS)
`define RFIFO_TMR_W      8
`endif

/* rfifo_pkg.sv */
// Types for the ripple FIFO host controller
package rfifo_pkg;
  typedef logic [8:0] rfifo_word_t;
  typedef struct packed {
    logic        valid;
    rfifo_word_t data;
  } rfifo_beat_t;
  typedef enum logic [2:0] {
    RF_CLR, RF_IDLE, RF_HIGH, RF_LOW
  } rfifo_stb_t;
endpackage : rfifo_pkg

/* rfifo_timer.sv */
// Small down counter timing strobe phases
`timescale 1ns/10ps
`default_nettype none
`include "rfifo_map.svh"
module rfifo_timer
  import rfifo_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  // Control
  input  wire logic                    load_i,
  input  wire logic [`RFIFO_TMR_W-1:0] value_i,
  output logic                         done_o
);
  logic [`RFIFO_TMR_W-1:0] cnt_r;
  assign done_o = (cnt_r == `RFIFO_TMR_W'(0));
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_r <= '0;
    else if (load_i)
      cnt_r <= value_i;
    else if (!done_o)
      cnt_r <= cnt_r - `RFIFO_TMR_W'(1);
  end
endmodule : rfifo_timer
`default_nettype wire

/* rfifo_host.sv */
// Host controller driving a clockless ripple FIFO over its pins
`timescale 1ns/10ps
`default_nettype none
`include "rfifo_map.svh"
module rfifo_host
  import rfifo_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  // Producer side: words to send
  input  wire logic         wr_valid_i,
  input  wire rfifo_word_t  wr_data_i,
  output logic              wr_ready_o,
  // Consumer side: words received
  output rfifo_beat_t       rd_beat_o,
  input  wire logic         rd_ready_i,
  // Host controls
  input  wire logic         burst_i,
  input  wire logic         out_en_i,
  output logic              init_done_o,
  // Device pins
  output logic              clear_all_n_o,
  output logic              push_strobe_o,
  output rfifo_word_t       write_word_o,
  input  wire logic         input_ready_flag_i,
  output logic              pop_strobe_o,
  input  wire rfifo_word_t  read_word_i,
  input  wire logic         output_valid_flag_i,
  output logic              out_en_n_o
);
  // ****************************************************
  // Reset pulse
  // ****************************************************
  logic                    clr_n_r;
  logic                    init_r;
  logic                    clr_done;
  logic [`RFIFO_TMR_W-1:0] clr_cnt_r;
  assign clr_done = (clr_cnt_r == `RFIFO_TMR_W'(`RFIFO_CLR_CYC));
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clr_cnt_r <= '0;
      clr_n_r   <= 1'b0;
      init_r    <= 1'b0;
    end
    else if (!clr_done)
      clr_cnt_r <= clr_cnt_r + `RFIFO_TMR_W'(1);
    else
    begin
      clr_n_r <= 1'b1;
      init_r  <= clr_n_r;
    end
  end
  assign clear_all_n_o = clr_n_r;
  assign init_done_o   = init_r;
  // ****************************************************
  // Push side
  // ****************************************************
  rfifo_stb_t              ps_r;
  rfifo_stb_t              ps_nxt;
  logic                    ps_done;
  logic                    ps_load;
  rfifo_word_t             wdat_r;
  logic [`RFIFO_CNT_W-1:0] level_r;
  logic                    push_ok;
  logic                    push_go;
  logic                    push_fin;
  logic                    pop_fin;
  // Burst ignores flag, bounded by depth
  assign push_ok  = burst_i ? (level_r < `RFIFO_CNT_W'(`RFIFO_DEPTH))
                            : input_ready_flag_i;
  // Flag taken as a level; waits rather than holding push
  assign push_go  = (ps_r == RF_IDLE) && wr_valid_i && push_ok && init_r;
  assign wr_ready_o = push_go;
  assign push_fin = (ps_r == RF_HIGH) && ps_done;
  always_comb
  begin
    ps_nxt  = ps_r;
    ps_load = 1'b0;
    case (ps_r)
      RF_CLR:  if (init_r) ps_nxt = RF_IDLE;
      RF_IDLE:
        if (push_go)
        begin
          ps_nxt  = RF_HIGH;
          ps_load = 1'b1;
        end
      RF_HIGH:
        if (ps_done)
        begin
          ps_nxt  = RF_LOW;
          ps_load = 1'b1;
        end
      RF_LOW:  if (ps_done) ps_nxt = RF_IDLE;
      default: ps_nxt = RF_IDLE;
    endcase
  end
  rfifo_timer u_push (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .load_i    (ps_load),
    .value_i   (`RFIFO_TMR_W'(`RFIFO_STB_CYC - 1)),
    .done_o    (ps_done)
  );
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ps_r   <= RF_CLR;
      wdat_r <= '0;
    end
    else
    begin
      ps_r <= ps_nxt;
      if (push_go)
        wdat_r <= wr_data_i;
    end
  end
  assign push_strobe_o = (ps_r == RF_HIGH);
  assign write_word_o  = wdat_r;
  // ****************************************************
  // Pop side
  // ****************************************************
  rfifo_stb_t  pp_r;
  rfifo_stb_t  pp_nxt;
  logic        pp_done;
  logic        pp_load;
  logic        pop_go;
  rfifo_beat_t beat_r;
  // Word sampled before the pop edge; a held word must be drained first
  // Released outputs are never popped
  assign pop_go = (pp_r == RF_IDLE) && output_valid_flag_i && !beat_r.valid
                  && out_en_i;
  assign pop_fin = (pp_r == RF_HIGH) && pp_done;
  always_comb
  begin
    pp_nxt  = pp_r;
    pp_load = 1'b0;
    case (pp_r)
      RF_CLR:  if (init_r) pp_nxt = RF_IDLE;
      RF_IDLE:
        if (pop_go)
        begin
          pp_nxt  = RF_HIGH;
          pp_load = 1'b1;
        end
      RF_HIGH:
        if (pp_done)
        begin
          pp_nxt  = RF_LOW;
          pp_load = 1'b1;
        end
      RF_LOW:  if (pp_done) pp_nxt = RF_IDLE;
      default: pp_nxt = RF_IDLE;
    endcase
  end
  rfifo_timer u_pop (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .load_i    (pp_load),
    .value_i   (`RFIFO_TMR_W'(`RFIFO_STB_CYC - 1)),
    .done_o    (pp_done)
  );
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pp_r   <= RF_CLR;
      beat_r <= '0;
    end
    else
    begin
      pp_r <= pp_nxt;
      if (pop_go)
        beat_r <= '{valid: 1'b1, data: read_word_i};
      else if (rd_ready_i)
        beat_r.valid <= 1'b0;
    end
  end
  assign pop_strobe_o = (pp_r == RF_HIGH);
  assign rd_beat_o    = beat_r;
  assign out_en_n_o   = !out_en_i;
  // ****************************************************
  // Fill level
  // ****************************************************
  // Limitation: counts whole strobe cycles, not ripple position
  // Depth bound
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      level_r <= '0;
    else if (push_go && !pop_fin)
      level_r <= level_r + `RFIFO_CNT_W'(1);
    else if (pop_fin && !push_go && level_r != '0)
      level_r <= level_r - `RFIFO_CNT_W'(1);
  end
  // ****************************************************
  // Checks
  // ****************************************************
  property p_push_width;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(push_strobe_o) |-> push_strobe_o [*3] ##1 !push_strobe_o;
  endproperty
  a_push_width: assert property (p_push_width) else $error("push width");
  property p_pop_width;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(pop_strobe_o) |-> pop_strobe_o [*3] ##1 !pop_strobe_o [*3];
  endproperty
  a_pop_width: assert property (p_pop_width) else $error("pop width");
  property p_no_overflow;
    @(posedge ref_clk_i) disable iff (rst_i)
      level_r <= `RFIFO_CNT_W'(`RFIFO_DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("overflow");
  property p_clear_first;
    @(posedge ref_clk_i) disable iff (rst_i)
      !clear_all_n_o |-> !push_strobe_o && !pop_strobe_o;
  endproperty
  a_clear_first: assert property (p_clear_first) else $error("strobe in clear");
  property p_push_flag;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(push_strobe_o) && !burst_i |-> $past(input_ready_flag_i);
  endproperty
  a_push_flag: assert property (p_push_flag) else $error("push without ready");
  property p_oe;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(pop_strobe_o) |-> $past(!out_en_n_o);
  endproperty
  a_oe: assert property (p_oe) else $error("oe level");
  sequence s_pop_cap;
    $rose(pop_strobe_o) ##0 rd_beat_o.valid;
  endsequence
  property p_pop_cap;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(pop_strobe_o) |-> s_pop_cap ##0 rd_beat_o.data == $past(read_word_i);
  endproperty
  a_pop_cap: assert property (p_pop_cap) else $error("pop capture");
  property p_word_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      push_strobe_o |=> $stable(write_word_o);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word moved");
endmodule : rfifo_host
`default_nettype wire

/* rfifo_dev_model.sv */
// Behavioural ripple FIFO device facing the host controller
`timescale 1ns/10ps
`default_nettype none
module rfifo_dev_model
  import rfifo_pkg::*;
(
  // Clock and device pins
  // Flags and strobes are the whole handshake
  input  wire logic         clk_i,
  input  wire logic         clr_n_i,
  input  wire logic         push_i,
  input  wire rfifo_word_t  din_i,
  input  wire logic         pop_i,
  input  wire logic         oe_n_i,
  output logic              rdy_o,
  output rfifo_word_t       dout_o,
  output logic              dval_o
);
  rfifo_word_t mem[$];
  rfifo_word_t in_w  = 9'h000;
  // Random state at power-up
  rfifo_word_t out_w = 9'h0a5;
  logic        in_b  = 1'b0;
  logic        out_v = 1'b0;
  logic        pop_b = 1'b0;
  logic [6:0]  n_mem = 7'h00;
  // Ready with a free input stage and room, and always while clear is held low
  assign rdy_o  = !clr_n_i || (!in_b && (n_mem + 7'(out_v) < 7'h40));
  // Valid only with a word in the output stage
  assign dval_o = out_v;
  // Released bus shows inverted data, never the last word
  assign dout_o = oe_n_i ? ~out_w : out_w;
  always @(posedge clk_i or negedge clr_n_i)
  begin
    if (!clr_n_i)
    begin
      mem.delete();
      in_b  <= 1'b0;
      out_v <= 1'b0;
      pop_b <= 1'b0;
      n_mem <= 7'h00;
    end
    else
    begin
      if (push_i && !in_b && rdy_o)
      begin
        in_b <= 1'b1;
        in_w <= din_i;
      end
      if (!push_i && in_b)
      begin
        mem.push_back(in_w);
        in_b <= 1'b0;
      end
      // Consume output word once per strobe
      if (pop_i && out_v && !pop_b)
      begin
        out_v <= 1'b0;
        pop_b <= 1'b1;
      end
      // Strobe must fall before next pop
      if (!pop_i)
        pop_b <= 1'b0;
      if (!out_v && !pop_b && mem.size() > 0)
      begin
        out_w <= mem.pop_front();
        out_v <= 1'b1;
      end
      n_mem <= 7'(mem.size());
    end
  end
endmodule : rfifo_dev_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the ripple FIFO host controller
`timescale 1ns/10ps
`default_nettype none
`include "rfifo_map.svh"
module tb_top
  import rfifo_pkg::*;
;
  logic        ref_clk_i  = 1'b0;
  logic        rst_i      = 1'b1;
  logic        wr_valid_i = 1'b0;
  logic        rd_ready_i = 1'b0;
  logic        burst_i    = 1'b0;
  logic        out_en_i   = 1'b1;
  rfifo_word_t wr_data_i  = 9'h000;
  logic        wr_ready_o, init_done_o, clear_all_n_o, push_strobe_o, pop_strobe_o;
  logic        out_en_n_o, input_ready_flag_i, output_valid_flag_i;
  rfifo_word_t write_word_o, read_word_i;
  rfifo_beat_t rd_beat_o;
  rfifo_word_t exp_q[$];
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          n_acc      = 0;
  int          seed       = 32'h177813fd;
  always #2.5 ref_clk_i = ~ref_clk_i;
  rfifo_host u_rfifo_host (
    .ref_clk_i           (ref_clk_i),
    .rst_i               (rst_i),
    .wr_valid_i          (wr_valid_i),
    .wr_data_i           (wr_data_i),
    .wr_ready_o          (wr_ready_o),
    .rd_beat_o           (rd_beat_o),
    .rd_ready_i          (rd_ready_i),
    .burst_i             (burst_i),
    .out_en_i            (out_en_i),
    .init_done_o         (init_done_o),
    .clear_all_n_o       (clear_all_n_o),
    .push_strobe_o       (push_strobe_o),
    .write_word_o        (write_word_o),
    .input_ready_flag_i  (input_ready_flag_i),
    .pop_strobe_o        (pop_strobe_o),
    .read_word_i         (read_word_i),
    .output_valid_flag_i (output_valid_flag_i),
    .out_en_n_o          (out_en_n_o)
  );
  rfifo_dev_model u_rfifo_dev_model (
    .clk_i(ref_clk_i), .clr_n_i(clear_all_n_o), .push_i(push_strobe_o),
    .din_i(write_word_o), .pop_i(pop_strobe_o), .oe_n_i(out_en_n_o),
    .rdy_o(input_ready_flag_i), .dout_o(read_word_i), .dval_o(output_valid_flag_i));
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Clear width after reset, then wait for init
  task automatic start_up;
    int lo = 0;
    for (int i = 0; i < 100 && init_done_o !== 1'b1; i++)
    begin
      @(posedge ref_clk_i);
      #1;
      if (clear_all_n_o === 1'b0)
        lo++;
    end
    check("clear low cycles", 10'(lo), 10'(`RFIFO_CLR_CYC));
    check("init done", 10'(init_done_o), 10'h001);
  endtask : start_up
  // Modes: 0 off, 1 on, 2 random; driver notes each word taken
  task automatic run(input int cyc, input int wm, input int rm);
    bit acc;
    for (int i = 0; i < cyc; i++)
    begin
      @(negedge ref_clk_i);
      acc = wr_valid_i && (wr_ready_o === 1'b1);
      if (acc)
      begin
        exp_q.push_back(wr_data_i);
        n_acc++;
      end
      @(posedge ref_clk_i);
      #1;
      if (!wr_valid_i || acc || wm == 0)
      begin
        wr_valid_i = (wm == 1) || (wm == 2 && ($random(seed) & 1) == 1);
        wr_data_i  = 9'($random(seed));
      end
      rd_ready_i = (rm == 1) || (rm == 2 && ($random(seed) & 1) == 1);
    end
  endtask : run
  task automatic drained;
    run(900, 0, 1);
    check("words left", 10'(exp_q.size()), 10'h000);
  endtask : drained
  // Oldest note against each delivered word
  always @(negedge ref_clk_i)
    if (rd_beat_o.valid === 1'b1 && rd_ready_i)
    begin
      if (exp_q.size() == 0)
        check("extra word", 10'h001, 10'h000);
      else
        check("read word", 10'(rd_beat_o.data), 10'(exp_q.pop_front()));
    end
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    start_up();
    // Stalled consumer: device full plus one held beat
    run(700, 1, 0);
    check("words taken", 10'(n_acc), 10'h041);
    check("ready when full", 10'(wr_ready_o), 10'h000);
    drained();
    burst_i = 1'b1;
    run(3000, 2, 2);
    drained();
    burst_i = 1'b0;
    run(2000, 2, 2);
    drained();
    out_en_i = 1'b0;
    #1;
    check("output enable", 10'(out_en_n_o), 10'h001);
    run(200, 1, 2);
    check("beat while disabled", 10'(rd_beat_o.valid), 10'h000);
    rst_i = 1'b1;
    #1;
    check("clear in reset", 10'(clear_all_n_o), 10'h000);
    check("beat in reset", 10'(rd_beat_o.valid), 10'h000);
    exp_q.delete();
    wr_valid_i = 1'b0;
    out_en_i   = 1'b1;
    repeat (10) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    start_up();
    run(600, 2, 1);
    drained();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
